//--- scrb_bank.sv
/*
 System configuration register bank: memory alias select, DMA request
 steering and interrupt-line port select, on a classic Wishbone slave.
 Assumes boot_pin and boot option bits are stable levels from outside;
 the pin is synchronised, the option bits are held static after reset.
*/
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "scrb_cfg.svh"

module scrb_bank #(
    parameter int LINES = 16
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Boot straps
    input wire logic boot_pin,
    input wire logic boot_select_option,
    input wire logic boot_option_high,
    input wire logic boot_option_low,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`SCRB_ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // Memory alias at address zero
    output logic [1:0] mem_map_sel,
    // DMA steering: one-hot channel 1 / channel 2 per request, both low during reset
    output logic serial_rx_dma_ch1,
    output logic serial_rx_dma_ch2,
    output logic serial_tx_dma_ch1,
    output logic serial_tx_dma_ch2,
    output logic converter_dma_ch1,
    output logic converter_dma_ch2,
    // Port B select per interrupt line (0 = port A)
    output logic [LINES-1:0] irq_line_source
);

    logic boot_meta_q;
    logic boot_sync_q;
    logic strap_pending_q;
    logic [2:0] mem_mode_q;
    logic serial_rx_dma_remap_q;
    logic serial_tx_dma_remap_q;
    logic converter_dma_remap_q;
    wire [4*LINES-1:0] src_q;
    logic ack_q;
    logic err_q;
    logic [31:0] rdat_q;
    logic [1:0] map_q;
    logic [5:0] dma_q;
    wire [LINES-1:0] line_q;

    wire req = wb_cyc_i & wb_stb_i & ~ack_q & ~err_q;
    wire hit_cfg = wb_adr_i == `SCRB_OFS_CFG;
    wire hit_s1 = wb_adr_i == `SCRB_OFS_SRC1;
    wire hit_s2 = wb_adr_i == `SCRB_OFS_SRC2;
    wire hit_s3 = wb_adr_i == `SCRB_OFS_SRC3;
    wire hit_s4 = wb_adr_i == `SCRB_OFS_SRC4;
    wire hit_stat = wb_adr_i == `SCRB_OFS_MAPSTAT;
    wire mapped = hit_cfg | hit_s1 | hit_s2 | hit_s3 | hit_s4 | hit_stat;
    // Writes land at the edge where the master samples ack, request still held
    wire wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_q & mapped;
    wire [31:0] bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                         {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire [3:0] hit_src = {hit_s4, hit_s3, hit_s2, hit_s1};

    // Boot mode as seen at reset release: pin high selects option bits
    wire [2:0] boot_mode = boot_sync_q ?
        {boot_select_option, boot_option_high, 1'b1} :
        {2'b00, boot_option_low & boot_select_option};

    // Alias decode
    wire map_iap = mem_mode_q[2] & mem_mode_q[0];
    wire map_sys = mem_mode_q == 3'b001;
    wire map_ram = mem_mode_q == 3'b011;
    scrb_pkg::scrb_map_type map_d;
    assign map_d = map_iap ? scrb_pkg::SCRB_MAP_IAP :
                   map_sys ? scrb_pkg::SCRB_MAP_SYS_FLASH :
                   map_ram ? scrb_pkg::SCRB_MAP_RAM :
                   scrb_pkg::SCRB_MAP_MAIN_FLASH;

    wire [31:0] cfg_rd = {21'h0, serial_rx_dma_remap_q, serial_tx_dma_remap_q,
                          converter_dma_remap_q, 5'h0, mem_mode_q};
    wire [31:0] stat_rd = {30'h0, map_q};
    wire [4*LINES-1:0] src_ext = src_q;
    wire [31:0] rd_d = hit_cfg ? cfg_rd :
                       hit_s1 ? {16'h0, src_ext[15:0]} :
                       hit_s2 ? {16'h0, src_ext[31:16]} :
                       hit_s3 ? {16'h0, src_ext[47:32]} :
                       hit_s4 ? {16'h0, src_ext[63:48]} :
                       hit_stat ? stat_rd : 32'h0000_0000;
    wire [31:0] cfg_new = (cfg_rd & ~bmask) | (wb_dat_i & bmask);

    always_ff @(posedge core_clk) begin
        boot_meta_q <= boot_pin;
        boot_sync_q <= boot_meta_q;
    end

    // Memory select and DMA remap bits; straps land on the first clock edge after release
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            strap_pending_q <= 1'b1;
            mem_mode_q <= 3'h0;
            serial_rx_dma_remap_q <= 1'b0;
            serial_tx_dma_remap_q <= 1'b0;
            converter_dma_remap_q <= 1'b0;
        end else if (strap_pending_q) begin
            strap_pending_q <= 1'b0;
            mem_mode_q <= boot_mode;
        end else if (wr && hit_cfg) begin
            mem_mode_q <= cfg_new[`SCRB_MEM_MSB:`SCRB_MEM_LSB];
            serial_rx_dma_remap_q <= cfg_new[`SCRB_RX_BIT];
            serial_tx_dma_remap_q <= cfg_new[`SCRB_TX_BIT];
            converter_dma_remap_q <= cfg_new[`SCRB_CONV_BIT];
        end
    end

    // Source fields, four lines per register
    genvar g;
    generate
        for (g = 0; g < LINES; g++) begin : g_line
            localparam int R = g / 4;
            localparam int F = g % 4;
            logic [3:0] field_q;
            logic port_b_q;
            always_ff @(posedge core_clk) begin
                if (!rstn) begin
                    field_q <= 4'(`SCRB_SRC_RESET);
                end else if (wr && hit_src[R] && wb_sel_i[F/2]) begin
                    field_q <= wb_dat_i[4*F +: 4];
                end
            end
            always_ff @(posedge core_clk) begin
                if (!rstn) begin
                    port_b_q <= 1'b0;
                end else begin
                    port_b_q <= field_q == `SCRB_SRC_PORT_B;
                end
            end
            assign src_q[4*g +: 4] = field_q;
            assign line_q[g] = port_b_q;
        end
    endgenerate

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            ack_q <= 1'b0;
            err_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
            map_q <= 2'h0;
            dma_q <= 6'h00;
        end else begin
            ack_q <= req & mapped;
            err_q <= req & ~mapped;
            rdat_q <= rd_d;
            map_q <= map_d;
            dma_q <= {serial_rx_dma_remap_q, ~serial_rx_dma_remap_q,
                      ~serial_tx_dma_remap_q, serial_tx_dma_remap_q,
                      ~converter_dma_remap_q, converter_dma_remap_q};
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_err_o = err_q;
    assign wb_dat_o = rdat_q;
    assign mem_map_sel = map_q;
    assign serial_rx_dma_ch1 = dma_q[5];
    assign serial_rx_dma_ch2 = dma_q[4];
    assign serial_tx_dma_ch1 = dma_q[3];
    assign serial_tx_dma_ch2 = dma_q[2];
    assign converter_dma_ch1 = dma_q[1];
    assign converter_dma_ch2 = dma_q[0];
    assign irq_line_source = line_q;

    // Checks
    sequence s_cfg_write;
        wr && hit_cfg && !strap_pending_q && wb_sel_i[0];
    endsequence
    sequence s_cfg_hi_write;
        wr && hit_cfg && !strap_pending_q && wb_sel_i[1];
    endsequence
    sequence s_cfg_read;
        req && !wb_we_i && hit_cfg;
    endsequence
    sequence s_stat_read;
        req && !wb_we_i && hit_stat;
    endsequence
    sequence s_answer_once;
        (wb_ack_o ^ wb_err_o) ##1 !wb_ack_o && !wb_err_o;
    endsequence

    a_mem_write: assert property (@(posedge core_clk) disable iff (!rstn)
        s_cfg_write |=> mem_mode_q == $past(wb_dat_i[2:0]))
        else $error("memory select not written");
    a_strap_load: assert property (@(posedge core_clk) disable iff (!rstn)
        rstn && strap_pending_q |=> mem_mode_q == $past(boot_mode))
        else $error("strap not loaded");
    a_main_flash: assert property (@(posedge core_clk) disable iff (!rstn)
        !mem_mode_q[0] && $stable(mem_mode_q) |=> map_q == 2'h0)
        else $error("main flash not mapped");
    a_sys_flash: assert property (@(posedge core_clk) disable iff (!rstn)
        mem_mode_q == 3'b001 |=> map_q == 2'h1)
        else $error("system flash not mapped");
    a_ram_map: assert property (@(posedge core_clk) disable iff (!rstn)
        mem_mode_q == 3'b011 |=> map_q == 2'h3)
        else $error("RAM not mapped");
    a_iap_map: assert property (@(posedge core_clk) disable iff (!rstn)
        mem_mode_q[2] && mem_mode_q[0] |=> map_q == 2'h2)
        else $error("IAP memory not mapped");
    a_reserved_map: assert property (@(posedge core_clk) disable iff (!rstn)
        mem_mode_q == 3'b100 || mem_mode_q == 3'b110 |=> map_q == 2'h0)
        else $error("reserved code not on main flash");
    a_rx_steer: assert property (@(posedge core_clk) disable iff (!rstn)
        rstn |=> serial_rx_dma_ch1 == $past(serial_rx_dma_remap_q)
            && serial_rx_dma_ch1 != serial_rx_dma_ch2)
        else $error("receive DMA steering wrong");
    a_tx_steer: assert property (@(posedge core_clk) disable iff (!rstn)
        rstn |=> serial_tx_dma_ch2 == $past(serial_tx_dma_remap_q)
            && serial_tx_dma_ch1 != serial_tx_dma_ch2)
        else $error("transmit DMA steering wrong");
    a_conv_steer: assert property (@(posedge core_clk) disable iff (!rstn)
        rstn |=> converter_dma_ch2 == $past(converter_dma_remap_q)
            && converter_dma_ch1 != converter_dma_ch2)
        else $error("converter DMA steering wrong");
    a_src_port: assert property (@(posedge core_clk) disable iff (!rstn)
        src_q[3:0] == 4'h1 |=> irq_line_source[0])
        else $error("line 0 not on port B");
    a_src_write: assert property (@(posedge core_clk) disable iff (!rstn)
        wr && hit_s1 && wb_sel_i[0] |=> src_q[7:4] == $past(wb_dat_i[7:4]))
        else $error("line 1 field not written");
    a_src4_write: assert property (@(posedge core_clk) disable iff (!rstn)
        wr && hit_s4 && wb_sel_i[1] |=> src_q[63:60] == $past(wb_dat_i[15:12]))
        else $error("line 15 field not written");
    a_bus_ack: assert property (@(posedge core_clk) disable iff (!rstn)
        req |=> s_answer_once)
        else $error("bus answer wrong");

    // Register reads, unmapped accesses and no answer on an idle bus
    a_cfg_read: assert property (@(posedge core_clk) disable iff (!rstn)
        s_cfg_read |=> wb_dat_o[2:0] == $past(mem_mode_q)
            && wb_dat_o[31:11] == 21'h0 && wb_dat_o[7:3] == 5'h0)
        else $error("config read wrong");
    a_stat_read: assert property (@(posedge core_clk) disable iff (!rstn)
        s_stat_read |=> wb_dat_o == {30'h0, $past(map_q)})
        else $error("status read wrong");
    a_src2_read: assert property (@(posedge core_clk) disable iff (!rstn)
        req && !wb_we_i && hit_s2 |=> wb_dat_o == {16'h0, $past(src_q[31:16])})
        else $error("source register 2 read wrong");
    a_err_unmapped: assert property (@(posedge core_clk) disable iff (!rstn)
        req && !mapped |=> wb_err_o && wb_dat_o == 32'h0000_0000)
        else $error("unmapped access not refused");
    a_unmapped_keep: assert property (@(posedge core_clk) disable iff (!rstn)
        req && wb_we_i && !mapped |=> ##1 $stable(src_q) && $stable(mem_mode_q))
        else $error("unmapped write changed state");
    a_no_ack_idle: assert property (@(posedge core_clk) disable iff (!rstn)
        !wb_cyc_i |=> !wb_ack_o && !wb_err_o)
        else $error("answer without request");

    // Writes and their absence
    a_dma_write: assert property (@(posedge core_clk) disable iff (!rstn)
        s_cfg_hi_write |=> {serial_rx_dma_remap_q, serial_tx_dma_remap_q,
            converter_dma_remap_q} == $past(wb_dat_i[10:8]))
        else $error("DMA remap bits not written");
    a_mem_hold: assert property (@(posedge core_clk) disable iff (!rstn)
        rstn && !strap_pending_q && !wr |=> $stable(mem_mode_q))
        else $error("memory select changed without write");
    a_src_low: assert property (@(posedge core_clk) disable iff (!rstn)
        wr && hit_s1 && wb_sel_i[0] |=> src_q[3:0] == $past(wb_dat_i[3:0]))
        else $error("line 0 field not written");
    a_sel_gate: assert property (@(posedge core_clk) disable iff (!rstn)
        wr && hit_s1 && !wb_sel_i[0] |=> $stable(src_q[7:0]))
        else $error("masked byte written");

    // Line select and strap
    a_port_a: assert property (@(posedge core_clk) disable iff (!rstn)
        src_q[3:0] == `SCRB_SRC_PORT_A |=> !irq_line_source[0])
        else $error("line 0 not on port A");
    a_line15_port: assert property (@(posedge core_clk) disable iff (!rstn)
        src_q[63:60] == `SCRB_SRC_PORT_B |=> irq_line_source[15])
        else $error("line 15 not on port B");
    a_strap_pin_low: assert property (@(posedge core_clk) disable iff (!rstn)
        rstn && strap_pending_q && !boot_sync_q |=> mem_mode_q[2:1] == 2'b00)
        else $error("low boot pin strap wrong");
    a_sync_stage: assert property (@(posedge core_clk) disable iff (!rstn)
        rstn |=> boot_sync_q == $past(boot_meta_q))
        else $error("boot pin synchroniser broken");

endmodule

//--- scrb_cfg.svh
/*
 Register offsets, field positions, reset values and codes of the
 system configuration register bank. Assumes a 32-bit word bus.
*/
`ifndef SCRB_CFG_SVH
`define SCRB_CFG_SVH
`define SCRB_OFS_CFG 8'h00
`define SCRB_OFS_SRC1 8'h08
`define SCRB_OFS_SRC2 8'h0C
`define SCRB_OFS_SRC3 8'h10
`define SCRB_OFS_SRC4 8'h14
`define SCRB_OFS_MAPSTAT 8'h18
`define SCRB_MEM_LSB 0
`define SCRB_MEM_MSB 2
`define SCRB_CONV_BIT 8
`define SCRB_TX_BIT 9
`define SCRB_RX_BIT 10
`define SCRB_SRC_RESET 32'h0000_0000
`define SCRB_SRC_PORT_A 4'h0
`define SCRB_SRC_PORT_B 4'h1
`define SCRB_ADDR_W 8
`endif

//--- scrb_pkg.sv
/*
 Types of the system configuration register bank.
 Assumes nothing of its surroundings.
*/
package scrb_pkg;
    typedef enum logic [1:0] {
        SCRB_MAP_MAIN_FLASH = 2'h0,
        SCRB_MAP_SYS_FLASH = 2'h1,
        SCRB_MAP_RAM = 2'h3,
        SCRB_MAP_IAP = 2'h2
    } scrb_map_type;
endpackage

//--- system_config_remap_bank_tb.sv
/*
 Self-checking bench for the system configuration register bank.
 Assumes scrb_cfg.svh and scrb_pkg are compiled first; Wishbone classic master.
*/
`timescale 1ns/1ps
`include "scrb_cfg.svh"

module system_config_remap_bank_tb;
    logic core_clk = 1'b0, rstn = 1'b0;
    logic boot_pin = 1'b0, boot_select_option = 1'b0, boot_option_high = 1'b0;
    logic boot_option_low = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, shd [4], r;
    logic wb_ack_o, wb_err_o, e;
    logic serial_rx_dma_ch1, serial_rx_dma_ch2, serial_tx_dma_ch1, serial_tx_dma_ch2;
    logic converter_dma_ch1, converter_dma_ch2;
    logic [1:0] mem_map_sel;
    logic [15:0] irq_line_source;
    int n_fail = 0, checked = 0, cycles = 0;

    scrb_bank #(.LINES(16)) dut (.core_clk, .rstn, .boot_pin, .boot_select_option,
        .boot_option_high, .boot_option_low, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .mem_map_sel,
        .serial_rx_dma_ch1, .serial_rx_dma_ch2, .serial_tx_dma_ch1, .serial_tx_dma_ch2,
        .converter_dma_ch1, .converter_dma_ch2, .irq_line_source);

    initial forever #2 core_clk = ~core_clk;

    function automatic logic [1:0] exp_map(input logic [2:0] m);
        if (!m[0]) return scrb_pkg::SCRB_MAP_MAIN_FLASH;
        if (m == 3'h1) return scrb_pkg::SCRB_MAP_SYS_FLASH;
        if (m == 3'h3) return scrb_pkg::SCRB_MAP_RAM;
        return scrb_pkg::SCRB_MAP_IAP;
    endfunction

    function automatic logic [15:0] exp_irq();
        logic [15:0] v;
        for (int l = 0; l < 16; l++) v[l] = (shd[l / 4][(l % 4) * 4 +: 4] == 4'h1);
        return v;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        do begin
            @(posedge core_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
        r = wb_dat_o;
        e = wb_err_o;
        if (n >= 20) chk(32'h1, 32'h0, "no bus answer");
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask

    task automatic chk_cfg(input logic [2:0] m, input logic [2:0] dma);
        wb(1'b0, `SCRB_OFS_CFG, 32'h0, 4'hF);
        chk(r, {21'h0, dma, 5'h0, m}, "config readback");
        chk({30'h0, mem_map_sel}, {30'h0, exp_map(m)}, "memory alias");
        chk({26'h0, serial_rx_dma_ch1, serial_rx_dma_ch2, serial_tx_dma_ch1,
             serial_tx_dma_ch2, converter_dma_ch1, converter_dma_ch2},
            {26'h0, dma[2], !dma[2], !dma[1], dma[1], !dma[0], dma[0]}, "dma steer");
        wb(1'b0, `SCRB_OFS_MAPSTAT, 32'h0, 4'hF);
        chk(r, {30'h0, exp_map(m)}, "alias status");
    endtask

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            finish_test();
        end
    end

    initial begin
        logic [2:0] boot, m;
        logic [3:0] s;
        logic [31:0] d;
        int i;
        void'($urandom(32'h50dd9b6c));
        for (int k = 0; k < 6; k++) begin
            @(posedge core_clk);
            {boot_pin, boot_select_option, boot_option_high, boot_option_low} <= 4'($urandom);
            rstn <= 1'b0;
            repeat (10) @(posedge core_clk);
            boot = boot_pin ? {boot_select_option, boot_option_high, 1'b1}
                            : {2'b00, boot_option_low & boot_select_option};
            rstn <= 1'b1;
            repeat (3) @(posedge core_clk);
            chk_cfg(boot, 3'h0);
            for (int j = 0; j < 4; j++) begin
                wb(1'b0, 8'h08 + 8'(4 * j), 32'h0, 4'hF);
                chk(r, `SCRB_SRC_RESET, "source reset");
                shd[j] = 32'h0;
            end
            $display("Reset test %0d done", k);
        end
        for (int k = 0; k < 16; k++) begin
            m = 3'(k);
            d = {21'h0, 3'($urandom), 5'h0, m};
            wb(1'b1, `SCRB_OFS_CFG, d, 4'hF);
            chk_cfg(m, d[10:8]);
        end
        $display("Memory select and dma test done");
        for (int k = 0; k < 40; k++) begin
            i = $urandom_range(3);
            d = {16'h0, 4'($urandom_range(2)), 4'($urandom_range(2)),
                 4'($urandom_range(2)), 4'($urandom_range(2))};
            s = (k < 4) ? 4'h3 : 4'($urandom);
            wb(1'b1, 8'h08 + 8'(4 * i), d, s);
            for (int b = 0; b < 4; b++) if (s[b]) shd[i][8 * b +: 8] = d[8 * b +: 8];
            wb(1'b0, 8'h08 + 8'(4 * i), 32'h0, 4'hF);
            chk(r, shd[i], "source readback");
            chk({16'h0, irq_line_source}, {16'h0, exp_irq()}, "line source");
        end
        $display("Interrupt source test done");
        for (int k = 0; k < 3; k++) begin
            wb(1'b1, (k == 0) ? 8'h04 : (k == 1) ? 8'h1C : 8'h40, 32'hFFFF, 4'hF);
            chk({31'h0, e}, 32'h1, "unmapped answer");
            wb(1'b0, (k == 0) ? 8'h04 : (k == 1) ? 8'h1C : 8'h40, 32'h0, 4'hF);
            chk({31'h0, e}, 32'h1, "unmapped read answer");
            chk(r, 32'h0, "unmapped read data");
        end
        chk({16'h0, irq_line_source}, {16'h0, exp_irq()}, "line source kept");
        $display("Unmapped test done");
        finish_test();
    end
endmodule
